// ===== iopr_top.v
`timescale 1ns/1ns
module iopr_top (
   // Clock, reset and enable
   input wire clk,
   input wire rst,
   input wire ce,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // First port pins
   input wire [7:0] p0_in,
   output reg [7:0] p0_out,
   output reg [7:0] p0_oe,
   // Second port pins
   input wire [7:0] p1_in,
   output reg [7:0] p1_out,
   output reg [7:0] p1_oe,
   // Third port pins
   input wire [7:0] p2_in,
   output reg [7:0] p2_out,
   output reg [7:0] p2_oe,
   // Fourth port pins
   input wire [7:0] p3_in,
   output reg [7:0] p3_out,
   output reg [7:0] p3_oe,
   // Reset pin
   input wire rst_pin_in,
   output wire rst_pin_out,
   output wire rst_pin_oe,
   // External memory bus from the core
   input wire [1:0] bus_mode,
   input wire bus_addr_phase,
   input wire [15:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wdata_en,
   output reg [7:0] bus_rdata,
   // Alternate function signals from the core
   input wire t2_clk_out,
   input wire isp_miso_out,
   input wire isp_miso_en,
   input wire serial_tx,
   input wire ext_wr_strobe_n,
   input wire ext_rd_strobe_n,
   input wire wdt_timeout,
   // Alternate function signals to the core
   output reg timer_two_count_input,
   output reg timer_two_trigger_input,
   output reg isp_mosi,
   output reg isp_sck,
   output reg serial_rx,
   output reg external_interrupt_zero,
   output reg external_interrupt_one,
   output reg timer_zero_input,
   output reg timer_one_input,
   output wire core_reset_req
);
`include "iopr_map.vh"
reg [7:0] aux_reg;
reg [7:0] p0_reg;
reg [7:0] p1_reg;
reg [7:0] p2_reg;
reg [7:0] p3_reg;
reg [7:0] ctrl_reg;
reg [11:0] addr_reg;
reg wr_reg;
reg rd_reg;
reg [7:0] p0_next;
reg [7:0] p0_oe_next;
reg [7:0] p1_next;
reg [7:0] p1_oe_next;
reg [7:0] p2_next;
reg [7:0] p2_oe_next;
reg [7:0] p3_next;
reg [7:0] p3_oe_next;
reg [31:0] rdata_next;
wire ext_bus;
wire take;
wire [7:0] wbyte;
wire rto_disable;
wire wdt_req;

// While the clock enable is low the bus is stalled, so no transfer is lost.
assign hreadyout = ce;
assign hresp = 1'b0;
assign take = hsel && hready && (htrans == `IOPR_HTRANS_NONSEQ) &&
   (hsize == `IOPR_HSIZE_WORD) && (haddr[1:0] == 2'b00);
assign wbyte = hwdata[7:0];
assign ext_bus = (bus_mode != `IOPR_MODE_PORT);
assign rto_disable = aux_reg[`IOPR_AUX_RTO_DIS];
assign wdt_req = wdt_timeout || ctrl_reg[`IOPR_CTRL_WDT];

// Bus register file: address phase captured, write in data phase.
always @(posedge clk) begin
   if (rst) begin
      addr_reg <= 12'h000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      aux_reg <= `IOPR_AUX_RESET;
      p0_reg <= `IOPR_PORT_RESET;
      p1_reg <= `IOPR_PORT_RESET;
      p2_reg <= `IOPR_PORT_RESET;
      p3_reg <= `IOPR_PORT_RESET;
      ctrl_reg <= 8'h00;
      hrdata <= 32'h00000000;
   end else if (ce) begin
      if (hready) begin
         addr_reg <= haddr[11:0];
         wr_reg <= take && hwrite;
         rd_reg <= take && !hwrite;
      end
      hrdata <= rdata_next;
      // The watchdog test request is a one-shot and clears itself.
      ctrl_reg <= ctrl_reg & `IOPR_CTRL_WDT_CLR;
      if (wr_reg) begin
         case (addr_reg)
            `IOPR_ADDR_AUX: aux_reg <= wbyte & `IOPR_AUX_MASK;
            `IOPR_ADDR_P0: p0_reg <= wbyte;
            `IOPR_ADDR_P1: p1_reg <= wbyte;
            `IOPR_ADDR_P2: p2_reg <= wbyte;
            `IOPR_ADDR_P3: p3_reg <= wbyte;
            `IOPR_ADDR_CTRL: ctrl_reg <= wbyte & `IOPR_CTRL_MASK;
            default: ctrl_reg <= ctrl_reg & `IOPR_CTRL_WDT_CLR;
         endcase
      end
   end
end

// Read data for the data phase; unmapped addresses read as zero.
always @* begin
   rdata_next = 32'h00000000;
   if (take && !hwrite) begin
      case (haddr[11:0])
         `IOPR_ADDR_AUX: rdata_next = {24'h000000, aux_reg};
         `IOPR_ADDR_P0: rdata_next = {24'h000000, p0_reg};
         `IOPR_ADDR_P1: rdata_next = {24'h000000, p1_reg};
         `IOPR_ADDR_P2: rdata_next = {24'h000000, p2_reg};
         `IOPR_ADDR_P3: rdata_next = {24'h000000, p3_reg};
         `IOPR_ADDR_PIN0: rdata_next = {24'h000000, p0_in};
         `IOPR_ADDR_PIN1: rdata_next = {24'h000000, p1_in};
         `IOPR_ADDR_PIN2: rdata_next = {24'h000000, p2_in};
         `IOPR_ADDR_PIN3: rdata_next = {24'h000000, p3_in};
         `IOPR_ADDR_CTRL: rdata_next = {24'h000000, ctrl_reg};
         `IOPR_ADDR_STAT: rdata_next = {29'h00000000, core_reset_req, rst_pin_oe, ext_bus};
         default: rdata_next = 32'h00000000;
      endcase
   end
end

// First port: open drain as a port, pushed low byte or data on the bus.
always @* begin
   p0_next = 8'h00;
   p0_oe_next = ~p0_reg;
   if (ext_bus) begin
      if (bus_addr_phase) begin
         p0_next = bus_addr[7:0];
         p0_oe_next = 8'hff;
      end else if (bus_wdata_en) begin
         p0_next = bus_wdata;
         p0_oe_next = 8'hff;
      end else begin
         // Released to read; the programmer's pull-ups hold it on verify.
         p0_oe_next = 8'h00;
      end
   end
end

// Third port: high address byte or its own latch.
always @* begin
   p2_next = p2_reg;
   p2_oe_next = ~p2_reg;
   case (bus_mode)
      `IOPR_MODE_CODE, `IOPR_MODE_DATA16: begin
         p2_next = bus_addr[15:8];
         p2_oe_next = 8'hff;
      end
      `IOPR_MODE_DATA8: begin
         p2_next = p2_reg;
         p2_oe_next = 8'hff;
      end
      default: begin
         p2_next = p2_reg;
         p2_oe_next = ~p2_reg;
      end
   endcase
end

// Second and fourth ports: pull-up pins, alternates gated by the latch except the ISP pins.
// A pin drives only a low level, except the timer-two clock and MISO outputs; a one is left to the pull-up.
always @* begin
   p1_next = 8'h00;
   p1_oe_next = ~p1_reg;
   if (ctrl_reg[`IOPR_CTRL_T2OUT] && p1_reg[0]) begin
      p1_next[0] = t2_clk_out;
      p1_oe_next[0] = 1'b1;
   end
   if (ctrl_reg[`IOPR_CTRL_ISP]) begin
      p1_next[6] = isp_miso_out;
      p1_oe_next[6] = isp_miso_en;
      p1_oe_next[5] = 1'b0;
      p1_oe_next[7] = 1'b0;
   end
   p3_next = 8'h00;
   p3_oe_next = ~p3_reg;
   p3_oe_next[1] = !(p3_reg[1] && serial_tx);
   p3_oe_next[6] = !(p3_reg[6] && ext_wr_strobe_n);
   p3_oe_next[7] = !(p3_reg[7] && ext_rd_strobe_n);
end

// Pin outputs and alternate inputs are registered.
always @(posedge clk) begin
   if (rst) begin
      p0_out <= 8'h00;
      p0_oe <= 8'h00;
      p1_out <= 8'h00;
      p1_oe <= 8'h00;
      p2_out <= 8'h00;
      p2_oe <= 8'h00;
      p3_out <= 8'h00;
      p3_oe <= 8'h00;
      bus_rdata <= 8'h00;
      timer_two_count_input <= 1'b1;
      timer_two_trigger_input <= 1'b1;
      isp_mosi <= 1'b1;
      isp_sck <= 1'b1;
      serial_rx <= 1'b1;
      external_interrupt_zero <= 1'b1;
      external_interrupt_one <= 1'b1;
      timer_zero_input <= 1'b1;
      timer_one_input <= 1'b1;
   end else if (ce) begin
      p0_out <= p0_next;
      p0_oe <= p0_oe_next;
      p1_out <= p1_next;
      p1_oe <= p1_oe_next;
      p2_out <= p2_next;
      p2_oe <= p2_oe_next;
      p3_out <= p3_next;
      p3_oe <= p3_oe_next;
      bus_rdata <= p0_in;
      timer_two_count_input <= p1_in[0];
      timer_two_trigger_input <= p1_in[1];
      isp_mosi <= p1_in[5];
      isp_sck <= p1_in[7];
      serial_rx <= p3_in[0];
      external_interrupt_zero <= p3_in[2];
      external_interrupt_one <= p3_in[3];
      timer_zero_input <= p3_in[4];
      timer_one_input <= p3_in[5];
   end
end

iopr_rst_pin u_rst_pin (
   .clk(clk),
   .rst(rst),
   .ce(ce),
   .rst_pin_in(rst_pin_in),
   .rst_pin_out(rst_pin_out),
   .rst_pin_oe(rst_pin_oe),
   .wdt_timeout(wdt_req),
   .reset_out_disable(rto_disable),
   .core_reset_req(core_reset_req)
);
endmodule // iopr_top

// ===== iopr_map.vh
`ifndef IOPR_MAP_VH
`define IOPR_MAP_VH
// Port latch and auxiliary register indexes; each byte address is four times its index.
`define IOPR_P0_INDEX 10'h080
`define IOPR_P1_INDEX 10'h090
`define IOPR_P2_INDEX 10'h0a0
`define IOPR_P3_INDEX 10'h0b0
`define IOPR_ADDR_AUX {`IOPR_AUX_INDEX, 2'b00}
`define IOPR_ADDR_P0 {`IOPR_P0_INDEX, 2'b00}
`define IOPR_ADDR_P1 {`IOPR_P1_INDEX, 2'b00}
`define IOPR_ADDR_P2 {`IOPR_P2_INDEX, 2'b00}
`define IOPR_ADDR_P3 {`IOPR_P3_INDEX, 2'b00}
// Byte addresses of the pin, control and status registers.
`define IOPR_ADDR_PIN0 12'h0c0
`define IOPR_ADDR_PIN1 12'h0c4
`define IOPR_ADDR_PIN2 12'h0c8
`define IOPR_ADDR_PIN3 12'h0cc
`define IOPR_ADDR_CTRL 12'h0d0
`define IOPR_ADDR_STAT 12'h0d4
// Auxiliary control register: index, reset value and field positions.
`define IOPR_AUX_INDEX 10'h08e
`define IOPR_AUX_RESET 8'h00
`define IOPR_AUX_ALE_OFF 0
`define IOPR_AUX_RTO_DIS 3
`define IOPR_AUX_MASK 8'h19
// Port latch reset value.
`define IOPR_PORT_RESET 8'hff
// Control register fields.
`define IOPR_CTRL_MASK 8'h0f
`define IOPR_CTRL_T2OUT 0
`define IOPR_CTRL_ISP 1
`define IOPR_CTRL_WDT 2
`define IOPR_CTRL_WDT_CLR 8'hfb
// Timing: oscillator periods of one machine cycle and reset figures.
`define IOPR_OSC_PER_MC 8'h0c
`define IOPR_RST_IN_MC 8'h02
`define IOPR_RST_OUT_OSC 7'h62
`define IOPR_CNT_W 7
// Bus mode values.
`define IOPR_MODE_PORT 2'h0
`define IOPR_MODE_CODE 2'h1
`define IOPR_MODE_DATA16 2'h2
`define IOPR_MODE_DATA8 2'h3
`define IOPR_HTRANS_NONSEQ 2'h2
`define IOPR_HSIZE_WORD 3'h2
`endif

// ===== iopr_rst_pin.v
`timescale 1ns/1ns
// Reset pin: input qualification and watchdog reset-out drive.
module iopr_rst_pin (
   // Clock and control
   input wire clk,
   input wire rst,
   input wire ce,
   // Pin
   input wire rst_pin_in,
   output reg rst_pin_out,
   output reg rst_pin_oe,
   // Core side
   input wire wdt_timeout,
   input wire reset_out_disable,
   output reg core_reset_req
);
`include "iopr_map.vh"
localparam [7:0] QUAL_CNT = `IOPR_OSC_PER_MC * `IOPR_RST_IN_MC;
localparam [6:0] OUT_CNT = `IOPR_RST_OUT_OSC;
reg [7:0] qual_reg;
reg [6:0] out_reg;
always @(posedge clk) begin
   if (rst) begin
      qual_reg <= 8'h00;
      out_reg <= 7'h00;
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
      core_reset_req <= 1'b0;
   end else if (ce) begin
      // The drive we make ourselves must not be mistaken for an external reset.
      if (rst_pin_in && !rst_pin_oe) begin
         if (qual_reg != QUAL_CNT)
            qual_reg <= qual_reg + 8'h01;
      end else begin
         qual_reg <= 8'h00;
      end
      core_reset_req <= rst_pin_in && !rst_pin_oe && (qual_reg >= QUAL_CNT - 8'h01);
      if (wdt_timeout && !reset_out_disable && out_reg == 7'h00) begin
         out_reg <= OUT_CNT;
         rst_pin_out <= 1'b1;
         rst_pin_oe <= 1'b1;
      end else if (out_reg != 7'h00) begin
         out_reg <= out_reg - 7'h01;
         rst_pin_out <= (out_reg != 7'h01);
         rst_pin_oe <= (out_reg != 7'h01);
      end
   end
end
endmodule // iopr_rst_pin

// ===== iopr_top_props.sv
`timescale 1ns/1ns
module iopr_top_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   input wire ce,
   // Core bus
   input wire [1:0] bus_mode,
   input wire bus_addr_phase,
   input wire [15:0] bus_addr,
   // Port pins
   input wire [7:0] p0_out,
   input wire [7:0] p0_oe,
   input wire [7:0] p2_out,
   input wire [7:0] p2_oe,
   input wire [7:0] p3_in,
   input wire [7:0] p3_out,
   input wire [7:0] p3_oe,
   // Alternate functions
   input wire ext_wr_strobe_n,
   input wire serial_rx,
   input wire external_interrupt_zero,
   input wire external_interrupt_one,
   input wire timer_zero_input,
   input wire timer_one_input,
   // Reset pin
   input wire rst_pin_in,
   input wire rst_pin_oe,
   input wire wdt_timeout,
   input wire core_reset_req
);
   reg [7:0] drv_cnt;
   reg [4:0] hi_cnt;
   reg [7:0] p3_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Counts cycles of reset-out drive and of qualified high reset-pin samples.
   always @(posedge clk) begin
      if (ce) p3_q <= p3_in;
      if (rst || !rst_pin_oe) drv_cnt <= 8'h00;
      else drv_cnt <= drv_cnt + 8'h01;
      if (rst || !rst_pin_in || rst_pin_oe) hi_cnt <= 5'h00;
      else if (hi_cnt != 5'h1f) hi_cnt <= hi_cnt + 5'h01;
   end
   a_p0_open_drain: assert property (
      $past(bus_mode) == 2'h0 |-> p0_out == 8'h00) else $error("first port drove high");
   a_p0_addr_out: assert property (
      $past(bus_mode) != 2'h0 && $past(bus_addr_phase)
      |-> {p0_oe, p0_out} == {8'hff, $past(bus_addr[7:0])}) else $error("low address wrong");
   a_p2_high_addr: assert property (
      $past(bus_mode) inside {2'h1, 2'h2}
      |-> {p2_oe, p2_out} == {8'hff, $past(bus_addr[15:8])}) else $error("high address wrong");
   a_p3_wr_strobe: assert property (
      !$past(ext_wr_strobe_n) |-> p3_oe[6] && !p3_out[6]) else $error("write strobe lost");
   a_p3_alt_in: assert property (
      {serial_rx, external_interrupt_zero, external_interrupt_one, timer_zero_input,
      timer_one_input} == {p3_q[0], p3_q[2], p3_q[3], p3_q[4], p3_q[5]})
      else $error("fourth port inputs wrong");
   a_rto_width: assert property (
      $fell(rst_pin_oe) |-> drv_cnt == 8'h62) else $error("reset-out width wrong");
   a_rto_start: assert property (
      $rose(rst_pin_oe) |-> $past(wdt_timeout)) else $error("reset-out without timeout");
   a_rst_qual_min: assert property (
      $rose(core_reset_req) |-> hi_cnt >= 5'h18) else $error("reset taken too early");
   a_rst_qual_max: assert property (
      hi_cnt == 5'h1b |-> core_reset_req) else $error("reset not taken");
endmodule // iopr_top_props

// ===== iopr_pins.sv
`timescale 1ns/1ns
// Outside world: pull-ups on ports one to three; first-port pins float when undriven unless pu0 pulls them up.
module iopr_pins (
   // Clock
   input wire clk,
   // Block drive
   input wire [31:0] pout,
   input wire [31:0] poe,
   input wire rst_pin_out,
   input wire rst_pin_oe,
   // Outside drive
   input wire [31:0] xval,
   input wire [31:0] xen,
   input wire pu0,
   input wire rdrv,
   // Pin levels
   output wire [31:0] pin,
   output wire rst_pin_in
);
   reg [7:0] flt = 8'h55;
   wire [31:0] any = poe | xen;
   always @(posedge clk) flt <= ~flt;
   // A floating pin toggles so that a stale level never reads as valid.
   assign pin = (~poe | pout) & (~xen | xval) & ~(~any & {24'h0, ~flt & {8{~pu0}}});
   assign rst_pin_in = rst_pin_oe ? rst_pin_out : rdrv;
endmodule // iopr_pins

// ===== iopr_top_test.sv
`timescale 1ns/1ns
module iopr_top_test;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, pu0 = 1'b0, rdrv = 1'b0;
   logic [1:0] htrans = 2'h0, bus_mode = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, xval = 32'h0, xen = 32'h0, rdata;
   logic [15:0] bus_addr = 16'h0;
   logic [7:0] bus_wdata = 8'h0;
   logic bus_addr_phase = 1'b0, bus_wdata_en = 1'b0, t2_clk_out = 1'b1, serial_tx = 1'b1;
   logic ext_wr_strobe_n = 1'b1, ext_rd_strobe_n = 1'b1, wdt_timeout = 1'b0;
   logic ce = 1'b1, isp_miso_out = 1'b1, isp_miso_en = 1'b0;
   wire [31:0] hrdata, pin, pout, poe;
   wire [8:0] alt;
   wire [7:0] bus_rdata;
   wire hreadyout, rst_pin_in, rst_pin_out, rst_pin_oe, core_reset_req;
   integer n_fail = 0, total_checks = 0;
   iopr_top u_dut (.clk, .rst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .p0_in(pin[7:0]),
      .p0_out(pout[7:0]), .p0_oe(poe[7:0]), .p1_in(pin[15:8]), .p1_out(pout[15:8]),
      .p1_oe(poe[15:8]), .p2_in(pin[23:16]), .p2_out(pout[23:16]), .p2_oe(poe[23:16]),
      .p3_in(pin[31:24]), .p3_out(pout[31:24]), .p3_oe(poe[31:24]), .rst_pin_in,
      .rst_pin_out, .rst_pin_oe, .bus_mode, .bus_addr_phase, .bus_addr, .bus_wdata,
      .bus_wdata_en, .bus_rdata, .t2_clk_out, .isp_miso_out, .isp_miso_en,
      .serial_tx, .ext_wr_strobe_n, .ext_rd_strobe_n, .wdt_timeout,
      .timer_two_count_input(alt[0]), .timer_two_trigger_input(alt[1]), .isp_mosi(alt[2]),
      .isp_sck(alt[3]), .serial_rx(alt[4]), .external_interrupt_zero(alt[5]),
      .external_interrupt_one(alt[6]), .timer_zero_input(alt[7]), .timer_one_input(alt[8]),
      .core_reset_req);
   iopr_pins u_pins (.clk, .pout, .poe, .rst_pin_out, .rst_pin_oe, .xval, .xen, .pu0, .rdrv,
      .pin, .rst_pin_in);
   initial forever #10 clk = ~clk;
   task conclude;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task rdy;
      integer n;
      begin
         n = 0;
         @(posedge clk);
         while (hreadyout !== 1'b1 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         if (n == 20) begin
            n_fail = n_fail + 1;
            conclude;
         end
      end
   endtask
   task bus(input w, input [11:0] a, input [31:0] d);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= {20'h0, a};
         rdy;
         htrans <= 2'h0;
         hwdata <= d;
         rdy;
         rdata = hrdata;
      end
   endtask
   task t_regs;
      begin
         bus(0, 12'h238, 32'h0);
         chk(rdata, 32'h0);
         bus(1, 12'h238, 32'hff);
         bus(0, 12'h238, 32'h0);
         chk(rdata, 32'h19);
         bus(0, 12'h2c0, 32'h0);
         chk(rdata, 32'hff);
         bus(1, 12'h0f0, 32'h5);
         bus(0, 12'h0f0, 32'h0);
         chk(rdata, 32'h0);
         bus(1, 12'h238, 32'h0);
      end
   endtask
   task t_port0;
      begin
         bus(1, 12'h200, 32'h0f);
         bus(1, 12'h240, 32'h3c);
         cyc(2);
         chk({poe[15:0], pout[15:0]}, 32'hc3f0_0000);
         bus(1, 12'h200, 32'hff);
         bus(1, 12'h240, 32'hff);
         xen <= 32'hff;
         xval <= 32'ha5;
         cyc(3);
         bus(0, 12'h0c0, 32'h0);
         chk(rdata, 32'ha5);
      end
   endtask
   task t_bus;
      integer k;
      begin
         bus(1, 12'h280, 32'h5a);
         xen <= 32'h0;
         for (k = 1; k < 4; k = k + 1) begin
            bus_mode <= k[1:0];
            bus_addr_phase <= 1'b1;
            bus_addr <= 16'hc3a5;
            cyc(2);
            chk({poe[23:16], pout[23:16], poe[7:0], pout[7:0]},
               {8'hff, (k == 3) ? 8'h5a : 8'hc3, 16'hffa5});
         end
         bus_addr_phase <= 1'b0;
         bus_wdata_en <= 1'b1;
         bus_wdata <= 8'h3c;
         cyc(2);
         chk({poe[7:0], pout[7:0]}, 32'hff3c);
         bus_wdata_en <= 1'b0;
         xen <= 32'hff;
         xval <= 32'h96;
         cyc(3);
         chk({24'h0, bus_rdata}, 32'h96);
         bus_mode <= 2'h0;
         xen <= 32'h0;
         pu0 <= 1'b1;
         cyc(3);
         bus(0, 12'h0c0, 32'h0);
         chk(rdata, 32'hff);
         pu0 <= 1'b0;
      end
   endtask
   task t_alt;
      integer k;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            xen <= 32'hff00_ff00;
            xval <= k ? 32'h3500_a100 : 32'hca00_5e00;
            cyc(2);
            chk({23'h0, alt}, {23'h0, xval[29:26], xval[24], xval[15], xval[13],
               xval[9:8]});
         end
         xen <= 32'h0;
         serial_tx <= 1'b0;
         ext_wr_strobe_n <= 1'b0;
         ext_rd_strobe_n <= 1'b0;
         t2_clk_out <= 1'b0;
         bus(1, 12'h0d0, 32'h1);
         cyc(2);
         chk({poe[31:24], pout[31:24], poe[15:8], pout[15:8]}, 32'hc200_0100);
         serial_tx <= 1'b1;
         ext_wr_strobe_n <= 1'b1;
         ext_rd_strobe_n <= 1'b1;
         isp_miso_out <= 1'b0;
         isp_miso_en <= 1'b1;
         bus(1, 12'h0d0, 32'h2);
         cyc(2);
         chk({16'h0, poe[15:8], pout[15:8]}, 32'h4000);
         isp_miso_en <= 1'b0;
         bus(1, 12'h0d0, 32'h0);
         // With the clock enable low the bus stalls and the inputs stay frozen.
         ce <= 1'b0;
         xen <= 32'hff00_0000;
         xval <= 32'h0;
         cyc(3);
         chk({31'h0, hreadyout}, 32'h0);
         chk({31'h0, alt[4]}, 32'h1);
         ce <= 1'b1;
         cyc(2);
         chk({31'h0, alt[4]}, 32'h0);
         xen <= 32'h0;
      end
   endtask
   task wdt_count(input [31:0] exp);
      integer i, k;
      begin
         wdt_timeout <= 1'b1;
         cyc(1);
         wdt_timeout <= 1'b0;
         k = 0;
         for (i = 0; i < 200; i = i + 1) begin
            @(posedge clk);
            if (rst_pin_oe === 1'b1 && rst_pin_out === 1'b1)
               k = k + 1;
         end
         chk(k, exp);
      end
   endtask
   task t_rst;
      begin
         rdrv <= 1'b1;
         cyc(22);
         rdrv <= 1'b0;
         cyc(2);
         chk({31'h0, core_reset_req}, 32'h0);
         rdrv <= 1'b1;
         cyc(28);
         chk({31'h0, core_reset_req}, 32'h1);
         rdrv <= 1'b0;
         cyc(3);
         wdt_count(32'h62);
         bus(1, 12'h238, 32'h08);
         wdt_count(32'h0);
      end
   endtask
   initial begin
      cyc(12);
      rst <= 1'b0;
      t_regs;
      t_port0;
      t_bus;
      t_alt;
      t_rst;
      conclude;
   end
endmodule // iopr_top_test
bind iopr_top iopr_top_props u_props (.clk, .rst, .ce, .bus_mode, .bus_addr_phase, .bus_addr,
   .p0_out, .p0_oe, .p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .ext_wr_strobe_n, .serial_rx,
   .external_interrupt_zero, .external_interrupt_one, .timer_zero_input, .timer_one_input,
   .rst_pin_in, .rst_pin_oe, .wdt_timeout, .core_reset_req);
